// ### rtl/wdw_pkg.sv
package wdw_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int          WDW_ADDR_W         = 16;
  localparam int          WDW_DATA_W         = 32;
  // register indices; the byte address is four times the index
  localparam logic [13:0] WDW_IDX_WDT_CTRL   = 14'h0ECE;
  localparam logic [13:0] WDW_IDX_PWR_FLAGS  = 14'h0FD7;
  localparam logic [13:0] WDW_IDX_IRQ_STATUS = 14'h0001;
  localparam logic [13:0] WDW_IDX_IRQ_MASK   = 14'h0002;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WDW_CS_LSB   = 4;
  localparam int WDW_CS_MSB   = 6;
  localparam int WDW_WIN_LSB  = 0;
  localparam int WDW_WIN_MSB  = 2;
  localparam int WDW_BIT_OVF  = 7;
  localparam int WDW_BIT_UNF  = 6;
  localparam int WDW_BIT_WV   = 5;
  localparam int WDW_BIT_TO   = 4;
  localparam int WDW_BIT_PIN  = 3;
  localparam int WDW_FLAG_LSB = 3;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] WDW_CS_LOW_OSC  = 3'h0;
  localparam logic [2:0] WDW_CS_MID_OSC  = 3'h1;
  localparam logic [2:0] WDW_FUSE_OPEN   = 3'h7;
  localparam logic [2:0] WDW_WIN_FULL    = 3'h7;
  localparam logic [2:0] WDW_CS_RST      = 3'h0;
  localparam logic [2:0] WDW_WIN_RST     = 3'h7;
  localparam logic [4:0] WDW_FLAGS_POR   = 5'h07;
  localparam logic [7:0] WDW_IRQ_RST     = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [15:0] WDW_PERIOD_TICKS = 16'h0400;
  localparam logic [15:0] WDW_EIGHTH_TICKS = WDW_PERIOD_TICKS >> 3;
  localparam logic [1:0]  WDW_FUSE_WAIT    = 2'h2;
  localparam int          WDW_SYNC_W       = 9;

  typedef enum logic [2:0] {
    WDW_ST_INIT = 3'b001,
    WDW_ST_RUN  = 3'b010,
    WDW_ST_TRIP = 3'b100
  } wdw_state_e;

endpackage

// ### rtl/wdw_sync.sv
`timescale 1ns/100ps
`default_nettype none

module wdw_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // ----------------------------------------------------------------
  // two flops per bit; the first is read only by the second
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_r[gi]   <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else if (clk_en) begin
          meta_r[gi]   <= async_in[gi];
          sync_out[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### rtl/wdw_top.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module wdw_top
  import wdw_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  clk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [WDW_ADDR_W-1:0] paddr,
  input  wire logic [WDW_DATA_W-1:0] pwdata,
  output var  logic                  pready,
  output var  logic [WDW_DATA_W-1:0] prdata,
  output var  logic                  pslverr,
  input  wire logic                  low_freq_oscillator,
  input  wire logic                  mid_freq_oscillator,
  input  wire logic                  ext_reset_pin_n,
  input  wire logic [2:0]            fuse_clock_select,
  input  wire logic [2:0]            fuse_window_select,
  input  wire logic                  stack_overflow_evt,
  input  wire logic                  stack_underflow_evt,
  input  wire logic                  watchdog_clear_instruction,
  output var  logic                  device_reset_req,
  output var  logic                  irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [WDW_SYNC_W-1:0] sync_q;
  logic                  lfo_s;
  logic                  mfo_s;
  logic                  pin_s;
  logic [2:0]            fcs_s;
  logic [2:0]            fwin_s;

  wdw_sync #(
    .WIDTH    (WDW_SYNC_W)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in ({low_freq_oscillator, mid_freq_oscillator, ext_reset_pin_n,
                fuse_clock_select, fuse_window_select}),
    .sync_out (sync_q)
  );

  assign lfo_s  = sync_q[8];
  assign mfo_s  = sync_q[7];
  assign pin_s  = sync_q[6];
  assign fcs_s  = sync_q[5:3];
  assign fwin_s = sync_q[2:0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wdw_state_e  state_r;
  wdw_state_e  state_nxt;
  logic [1:0]  init_cnt_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [2:0]  cs_r;
  logic [2:0]  win_r;
  logic [4:0]  flags_r;
  logic [4:0]  flags_nxt;
  logic [7:0]  stat_r;
  logic [7:0]  stat_nxt;
  logic [7:0]  mask_r;
  logic [7:0]  mask_nxt;
  logic        lfo_q_r;
  logic        mfo_q_r;
  logic        pin_q_r;
  logic        pin_seen_r;

  // ----------------------------------------------------------------
  // oscillator tick selection and pin reset detect
  // ----------------------------------------------------------------
  logic lfo_tick;
  logic mfo_tick;
  logic tick_sel;
  logic pin_evt;

  assign lfo_tick = lfo_s & ~lfo_q_r;
  assign mfo_tick = mfo_s & ~mfo_q_r;
  // reserved select codes stop the watchdog clock rather than guess
  assign tick_sel = (cs_r == WDW_CS_LOW_OSC) ? lfo_tick :
                    (cs_r == WDW_CS_MID_OSC) ? mfo_tick : 1'b0;
  // pin_seen_r masks the fake edge while the synchroniser fills
  assign pin_evt  = pin_seen_r & pin_q_r & ~pin_s;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfo_q_r    <= 1'b0;
      mfo_q_r    <= 1'b0;
      pin_q_r    <= 1'b0;
      pin_seen_r <= 1'b0;
    end else if (clk_en) begin
      lfo_q_r    <= lfo_s;
      mfo_q_r    <= mfo_s;
      pin_q_r    <= pin_s;
      pin_seen_r <= pin_seen_r | (state_r != WDW_ST_INIT);
    end
  end

  // ----------------------------------------------------------------
  // window and time-out decode
  // ----------------------------------------------------------------
  logic        run;
  logic [15:0] closed_limit;
  logic        closed;
  logic        clr_ok;
  logic        viol_evt;
  logic        to_evt;
  logic        reload;

  assign run          = (state_r == WDW_ST_RUN);
  // closed share is (7 - code) eighths of the period
  assign closed_limit = 16'(WDW_EIGHTH_TICKS * {13'h0000, WDW_WIN_FULL - win_r});
  assign closed       = (win_r != WDW_WIN_FULL) && (count_r < closed_limit);
  assign clr_ok       = run & watchdog_clear_instruction & ~closed;
  assign viol_evt     = run & watchdog_clear_instruction & closed;
  assign to_evt       = run & ~watchdog_clear_instruction & tick_sel &
                        (count_r == WDW_PERIOD_TICKS - 16'h0001);
  assign reload       = (state_r == WDW_ST_TRIP) ||
                        ((state_r == WDW_ST_INIT) && (init_cnt_r == WDW_FUSE_WAIT));

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      WDW_ST_INIT: begin
        count_nxt = 16'h0000;
        if (init_cnt_r == WDW_FUSE_WAIT) begin
          state_nxt = WDW_ST_RUN;
        end
      end
      WDW_ST_RUN: begin
        if (viol_evt || to_evt || pin_evt) begin
          state_nxt = WDW_ST_TRIP;
          count_nxt = 16'h0000;
        end else if (clr_ok) begin
          count_nxt = 16'h0000;
        end else if (tick_sel) begin
          count_nxt = count_r + 16'h0001;
        end
      end
      WDW_ST_TRIP: begin
        state_nxt = WDW_ST_RUN;
        count_nxt = 16'h0000;
      end
      default: begin
        state_nxt = WDW_ST_INIT;
        count_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r          <= WDW_ST_INIT;
      count_r          <= 16'h0000;
      init_cnt_r       <= 2'h0;
      device_reset_req <= 1'b0;
    end else if (clk_en) begin
      state_r          <= state_nxt;
      count_r          <= count_nxt;
      init_cnt_r       <= (init_cnt_r == WDW_FUSE_WAIT) ? init_cnt_r : init_cnt_r + 2'h1;
      device_reset_req <= viol_evt | to_evt;
    end
  end

  // ----------------------------------------------------------------
  // apb slave, one wait state on every access
  // ----------------------------------------------------------------
  logic        access;
  logic        commit;
  logic        sel_ctrl;
  logic        sel_flags;
  logic        sel_stat;
  logic        sel_mask;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_flags;
  logic        wr_stat;
  logic        wr_mask;
  logic [7:0]  rd_byte;

  assign access    = psel & penable;
  assign commit    = access & pready;
  assign sel_ctrl  = (paddr[15:2] == WDW_IDX_WDT_CTRL);
  assign sel_flags = (paddr[15:2] == WDW_IDX_PWR_FLAGS);
  assign sel_stat  = (paddr[15:2] == WDW_IDX_IRQ_STATUS);
  assign sel_mask  = (paddr[15:2] == WDW_IDX_IRQ_MASK);
  assign mapped    = sel_ctrl | sel_flags | sel_stat | sel_mask;
  assign wr_ctrl   = commit & pwrite & sel_ctrl;
  assign wr_flags  = commit & pwrite & sel_flags;
  assign wr_stat   = commit & pwrite & sel_stat;
  assign wr_mask   = commit & pwrite & sel_mask;
  assign rd_byte   = sel_ctrl  ? {1'b0, cs_r, 1'b0, win_r} :
                     sel_flags ? {flags_r, 3'h0} :
                     sel_stat  ? stat_r :
                     sel_mask  ? mask_r : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= access & ~pready;
      prdata  <= (access & ~pready & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      pslverr <= access & ~pready & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // watchdog control fields
  // ----------------------------------------------------------------
  // a device reset reloads the fields; the reload beats a racing write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_r  <= WDW_CS_RST;
      win_r <= WDW_WIN_RST;
    end else if (clk_en) begin
      if (reload) begin
        cs_r  <= (fcs_s == WDW_FUSE_OPEN) ? WDW_CS_RST : fcs_s;
        win_r <= fwin_s;
      end else if (wr_ctrl) begin
        if (fcs_s == WDW_FUSE_OPEN) begin
          cs_r <= pwdata[WDW_CS_MSB:WDW_CS_LSB];
        end
        if (fwin_s == WDW_FUSE_OPEN) begin
          win_r <= pwdata[WDW_WIN_MSB:WDW_WIN_LSB];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags; hardware events beat a racing firmware write
  // ----------------------------------------------------------------
  always_comb begin
    flags_nxt = wr_flags ? pwdata[7:WDW_FLAG_LSB] : flags_r;
    if (stack_overflow_evt) begin
      flags_nxt[WDW_BIT_OVF-WDW_FLAG_LSB] = 1'b1;
    end
    if (stack_underflow_evt) begin
      flags_nxt[WDW_BIT_UNF-WDW_FLAG_LSB] = 1'b1;
    end
    if (viol_evt) begin
      flags_nxt[WDW_BIT_WV-WDW_FLAG_LSB] = 1'b0;
    end
    if (to_evt) begin
      flags_nxt[WDW_BIT_TO-WDW_FLAG_LSB] = 1'b0;
    end
    if (pin_evt) begin
      flags_nxt[WDW_BIT_PIN-WDW_FLAG_LSB] = 1'b0;
    end
  end

  // only power-on reset loads WDW_FLAGS_POR; window, time-out and pin resets clear their own cause flag, stack overflow and underflow set theirs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= WDW_FLAGS_POR;
    end else if (clk_en) begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask, same bit layout as the flags
  // ----------------------------------------------------------------
  logic [7:0] ev_vec;

  assign ev_vec   = {stack_overflow_evt, stack_underflow_evt, viol_evt, to_evt, pin_evt,
                     3'h0};
  assign stat_nxt = (stat_r & ~(wr_stat ? pwdata[7:0] : 8'h00)) | ev_vec;
  assign mask_nxt = wr_mask ? (pwdata[7:0] & 8'hF8) : mask_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= WDW_IRQ_RST;
      mask_r <= WDW_IRQ_RST;
      irq    <= 1'b0;
    end else if (clk_en) begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq    <= |(stat_nxt & mask_nxt);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_clock_reserved: assert property ((cs_r != WDW_CS_LOW_OSC) && (cs_r != WDW_CS_MID_OSC)
                                     |-> !tick_sel)
    else $error("reserved clock select still ticks");
  a_window_full_open: assert property (run && (win_r == WDW_WIN_FULL) |-> !closed)
    else $error("full window code left a closed interval");
  a_cs_reload: assert property (clk_en && reload && (fcs_s == WDW_FUSE_OPEN)
                                |=> cs_r == WDW_CS_RST)
    else $error("clock select not reset to zero with open fuse");
  a_win_reload: assert property (clk_en && reload |=> win_r == $past(fwin_s))
    else $error("window field not loaded from fuse");
  a_ctrl_locked: assert property (clk_en && !reload && (fcs_s != WDW_FUSE_OPEN)
                                  |=> cs_r == $past(cs_r))
    else $error("locked clock select changed");
  a_ovf_sets: assert property (clk_en && stack_overflow_evt |=> flags_r[4] && stat_r[7])
    else $error("overflow event lost");
  a_unf_sets: assert property (clk_en && stack_underflow_evt |=> flags_r[3] && stat_r[6])
    else $error("underflow event lost");
  a_viol_reset: assert property (clk_en && viol_evt
                                 |=> !flags_r[2] && device_reset_req
                                     && (state_r == WDW_ST_TRIP))
    else $error("window violation did not clear flag and reset");
  a_timeout_reset: assert property (clk_en && to_evt
                                    |=> !flags_r[1] && device_reset_req ##1 count_r == 16'h0000)
    else $error("time-out did not clear flag and reset");
  a_pin_flag_kept: assert property (clk_en && !pin_evt && !wr_flags
                                    |=> $stable(flags_r[0]))
    else $error("pin flag changed without cause");
  a_clear_restart: assert property (clk_en && clr_ok && !pin_evt |=> count_r == 16'h0000)
    else $error("accepted clear did not restart the period");
  a_irq_level: assert property (##1 irq == |(stat_r & mask_r))
    else $error("interrupt output disagrees with status and mask");
  a_apb_answer: assert property (clk_en && access && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  c_violation: cover property (clk_en && viol_evt);
  c_timeout: cover property (clk_en && to_evt);
  c_clear_open: cover property (clk_en && clr_ok && (win_r != WDW_WIN_FULL));
  c_irq: cover property (irq);

endmodule

`default_nettype wire

// ### bench/test_watchdog_window_and_reset_flags.sv
`timescale 1ns/100ps
`default_nettype none

module test_watchdog_window_and_reset_flags;
  import wdw_pkg::*;

  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  localparam logic [15:0] A_CTRL   = {WDW_IDX_WDT_CTRL, 2'b00};
  localparam logic [15:0] A_FLAGS  = {WDW_IDX_PWR_FLAGS, 2'b00};
  localparam logic [15:0] A_STAT   = {WDW_IDX_IRQ_STATUS, 2'b00};
  localparam logic [15:0] A_MASK   = {WDW_IDX_IRQ_MASK, 2'b00};
  localparam logic [15:0] A_NONE   = 16'h0100;
  // window 011 keeps clears refused for the first half of the period
  localparam logic [2:0]  FUSE_WIN = 3'h3;
  localparam logic [7:0]  CTRL_LD  = {1'b0, WDW_CS_LOW_OSC, 1'b0, FUSE_WIN};
  // one-cycle event selects, ordered {overflow, underflow, clear}
  localparam logic [2:0]  EV_OVF   = 3'h4;
  localparam logic [2:0]  EV_UNF   = 3'h2;
  localparam logic [2:0]  EV_CLR   = 3'h1;

  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        low_osc, mid_osc, pin_n, ovf, unf, wclr, rst_req, irq;
  logic [2:0]  fuse_cs, fuse_win;
  int          fails, n_checks, n_resets;

  wdw_top dut (
    .clk(clk), .resetn(resetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .low_freq_oscillator(low_osc), .mid_freq_oscillator(mid_osc),
    .ext_reset_pin_n(pin_n), .fuse_clock_select(fuse_cs), .fuse_window_select(fuse_win),
    .stack_overflow_evt(ovf), .stack_underflow_evt(unf),
    .watchdog_clear_instruction(wclr), .device_reset_req(rst_req), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rst_req === 1'b1) begin
      n_resets++;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, {24'h000000, d}, rd, e);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string nm);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h00000000, rd, e);
    chk(nm, {24'h000000, exp}, rd);
  endtask

  task automatic pulse(input logic [2:0] sel);
    @(posedge clk);
    {ovf, unf, wclr} <= sel;
    @(posedge clk);
    {ovf, unf, wclr} <= 3'h0;
    repeat (6) @(posedge clk);
  endtask

  task automatic hard_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic tick(input int n, input bit mid);
    repeat (n) begin
      @(posedge clk);
      {mid_osc, low_osc} <= mid ? 2'b10 : 2'b01;
      repeat (2) @(posedge clk);
      {mid_osc, low_osc} <= 2'b00;
      @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_access;
    logic [31:0] rd;
    logic        e;
    rd_chk(A_FLAGS, 8'h38, "flags power-on");
    rd_chk(A_CTRL, CTRL_LD, "ctrl from fuses");
    wr(A_CTRL, 8'h15);
    rd_chk(A_CTRL, 8'h13, "ctrl lock");
    apb(1'b0, A_NONE, 32'h00000000, rd, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_events;
    pulse(EV_OVF);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_MASK, 8'hF8);
    repeat (3) @(posedge clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    pulse(EV_UNF);
    rd_chk(A_FLAGS, 8'hF8, "stack flags");
    rd_chk(A_STAT, 8'hC0, "status stack");
    wr(A_STAT, 8'hC0);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(A_FLAGS, 8'h38);
    rd_chk(A_FLAGS, 8'h38, "flags firmware clear");
  endtask

  task automatic t_window;
    tick(1100, 1'b0);
    chk("unselected source", 32'h0, n_resets);
    tick(600, 1'b1);
    pulse(EV_CLR);
    chk("open clear", 32'h0, n_resets);
    tick(100, 1'b1);
    pulse(EV_CLR);
    chk("closed clear", 32'h1, n_resets);
    rd_chk(A_FLAGS, 8'h18, "violation flag");
    rd_chk(A_CTRL, CTRL_LD, "ctrl reload");
  endtask

  task automatic t_timeout;
    tick(1020, 1'b0);
    chk("before time-out", 32'h1, n_resets);
    tick(8, 1'b0);
    chk("time-out", 32'h2, n_resets);
    rd_chk(A_FLAGS, 8'h08, "time-out flag");
    rd_chk(A_STAT, 8'h30, "status watchdog");
    wr(A_STAT, 8'h30);
  endtask

  task automatic t_pin;
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(A_FLAGS, 8'h00, "pin flag");
    chk("pin no reset req", 32'h2, n_resets);
    wr(A_FLAGS, 8'h38);
    rd_chk(A_FLAGS, 8'h38, "flags firmware set");
  endtask

  task automatic t_second_reset;
    pulse(EV_OVF);
    hard_reset;
    rd_chk(A_FLAGS, 8'h38, "flags second reset");
    rd_chk(A_CTRL, CTRL_LD, "ctrl second reset");
  endtask

  // a reserved source must stop the count; then lock the clock fuse and open the window fuse
  task automatic t_fuse_locks;
    wr(A_CTRL, 8'h27);
    rd_chk(A_CTRL, 8'h23, "ctrl reserved code");
    tick(1030, 1'b0);
    chk("reserved source", 32'h2, n_resets);
    fuse_cs  <= WDW_CS_MID_OSC;
    fuse_win <= WDW_WIN_FULL;
    hard_reset;
    rd_chk(A_CTRL, 8'h17, "ctrl locked fuses");
    wr(A_CTRL, 8'h25);
    rd_chk(A_CTRL, 8'h15, "ctrl window open");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn   = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 16'h0000;
    pwdata   = 32'h00000000;
    low_osc  = 1'b0;
    mid_osc  = 1'b0;
    pin_n    = 1'b1;
    ovf      = 1'b0;
    unf      = 1'b0;
    wclr     = 1'b0;
    fuse_cs  = WDW_FUSE_OPEN;
    fuse_win = FUSE_WIN;
    fails    = 0;
    n_checks = 0;
    n_resets = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    t_access;
    t_events;
    t_window;
    t_timeout;
    t_pin;
    t_second_reset;
    t_fuse_locks;
    end_of_test();
  end

  // the run needs about 15700 cycles; this leaves ample margin
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule

`default_nettype wire
